// file: tpw_pkg.sv
package tpw_pkg;
  // register addresses on the plain register port
  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] ADDR_COUNT = 4'h2;
  localparam logic [3:0] ADDR_CMP_A = 4'h3;
  localparam logic [3:0] ADDR_CMP_B = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] ADDR_PIN_DIR = 4'h7;
  // control a fields
  localparam int CA_MODE_A_POS = 6;
  localparam int CA_MODE_B_POS = 4;
  localparam int CA_WAVE_LO_POS = 0;
  localparam logic [7:0] CA_RW_MASK = 8'hf3;
  // control b fields
  localparam int CB_WAVE_HI_POS = 3;
  localparam int CB_CLKSEL_POS = 0;
  localparam logic [7:0] CB_RW_MASK = 8'h0f;
  // interrupt status bit positions
  localparam int IRQ_OVF_POS = 0;
  localparam int IRQ_MATCH_A_POS = 1;
  localparam int IRQ_MATCH_B_POS = 2;
  localparam logic [7:0] IRQ_USED_MASK = 8'h07;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  // count limits
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  // waveform mode encodings
  localparam logic [2:0] WM_PC_FIXED = 3'h1;
  localparam logic [2:0] WM_FAST_FIXED = 3'h3;
  localparam logic [2:0] WM_PC_VAR = 3'h5;
  localparam logic [2:0] WM_FAST_VAR = 3'h7;
  // output modes
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;
  // prescaler divisions; tap selects from control b clock select
  localparam int DIV_8 = 8;
  localparam int DIV_64 = 64;
  localparam int DIV_256 = 256;
  localparam int DIV_1024 = 1024;
  localparam int PRESC_W = 10;
endpackage : tpw_pkg

// file: tpw_waveform_unit.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module tpw_waveform_unit
  import tpw_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // interrupt
  output logic irq,
  // port pin data when the waveform does not own the pin
  input wire logic [1:0] portData,
  // waveform pins
  output logic waveOutA,
  output logic waveOutB,
  output logic [1:0] pinOut,
  output logic [1:0] pinOe
);

  // software-visible control registers
  logic [7:0] timerWaveformControlA;
  logic [7:0] timerControlBReg;

  // counter value and the compare pair that the match logic uses
  logic [7:0] countValue;
  logic [7:0] compareValueA;
  logic [7:0] compareValueB;

  // compare values as software wrote them; pwm modes copy them at top
  logic [7:0] bufCompareA;
  logic [7:0] bufCompareB;

  // interrupt status and mask share one layout
  logic [7:0] irqStatus;
  logic [7:0] irqMask;

  // pin direction: a one turns the pin driver on
  logic [1:0] pinDir;

  // count direction; only phase-correct mode ever counts down
  logic countDown;

  // free-running prescaler and the one-cycle timer tick it yields
  logic [PRESC_W-1:0] presc;
  logic tick;

  // decoded mode fields
  logic [2:0] waveMode;
  logic [1:0] outModeA;
  logic [1:0] outModeB;
  logic isFast;
  logic isPc;
  logic isPwm;

  // counter landmarks and the events they raise
  logic [7:0] topValue;
  logic atTop;
  logic atBottom;
  logic ovfEvent;
  logic matchA;
  logic matchB;

  // next-state values, applied only on a tick
  logic [7:0] next_count;
  logic next_countDown;
  logic next_waveA;
  logic next_waveB;

  // waveform level that a pin shows once its channel owns it
  logic pinWaveA;
  logic pinWaveB;

  // register port decode
  logic wrCtrlA;
  logic wrCtrlB;
  logic wrCount;
  logic wrCmpA;
  logic wrCmpB;
  logic rdStatus;

  // strobe decode; unmapped addresses fall through and are ignored
  assign wrCtrlA = regWrEn && regAddr == ADDR_CTRL_A;
  assign wrCtrlB = regWrEn && regAddr == ADDR_CTRL_B;
  assign wrCount = regWrEn && regAddr == ADDR_COUNT;
  assign wrCmpA = regWrEn && regAddr == ADDR_CMP_A;
  assign wrCmpB = regWrEn && regAddr == ADDR_CMP_B;
  assign rdStatus = regRdEn && regAddr == ADDR_IRQ_STATUS;

  // the mode bits take effect at once; a change in mid-period may give one
  // odd-length pulse, which software avoids by changing mode while stopped
  // modes four and six are reserved and behave like normal counting
  // mode decode: three-bit encoding spans both control registers
  assign outModeA = timerWaveformControlA[CA_MODE_A_POS +: 2];
  assign outModeB = timerWaveformControlA[CA_MODE_B_POS +: 2];
  assign waveMode = {timerControlBReg[CB_WAVE_HI_POS],
                     timerWaveformControlA[CA_WAVE_LO_POS +: 2]};
  assign isFast = waveMode == WM_FAST_FIXED || waveMode == WM_FAST_VAR;
  assign isPc = waveMode == WM_PC_FIXED || waveMode == WM_PC_VAR;
  // both pwm families double buffer the compare values
  assign isPwm = isFast || isPc;
  // variable top follows the active compare a value, loaded from the buffer at top
  assign topValue = (waveMode == WM_FAST_VAR || waveMode == WM_PC_VAR)
                    ? compareValueA : CNT_MAX;
  // with top from compare a, a count written above top while counting up runs on to max first
  assign atTop = countValue == topValue;
  assign atBottom = countValue == CNT_BOTTOM;

  // prescaler: free running counter, tap picked by clock select
  // it is shared and never restarted, so the first tick after a new
  // selection may come early by up to one divided period
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end

  // one-cycle tick per selected division; selection zero stops the timer
  // codes six and seven have no source here and stop the timer as well
  // the taps are the low bits of one counter, so all rates stay in step
  always_comb begin
    unique case (timerControlBReg[CB_CLKSEL_POS +: 3])
      3'h1: tick = 1'b1;
      3'h2: tick = presc[$clog2(DIV_8)-1:0] == '1;
      3'h3: tick = presc[$clog2(DIV_64)-1:0] == '1;
      3'h4: tick = presc[$clog2(DIV_256)-1:0] == '1;
      3'h5: tick = presc[$clog2(DIV_1024)-1:0] == '1;
      default: tick = 1'b0;
    endcase
  end

  // counter sequence per mode
  // fast pwm wraps from top straight to bottom; phase-correct turns at
  // both ends, so top and bottom each stand for a single tick
  // in other modes the counter counts up, and mode two clears it on compare a
  always_comb begin
    next_count = countValue + 8'h01;
    next_countDown = countDown;
    if (isFast) begin
      next_countDown = 1'b0;
      if (atTop) begin
        next_count = CNT_BOTTOM;
      end
    end else if (isPc) begin
      if (!countDown && atTop) begin
        next_countDown = 1'b1; // top stands for this one tick
        next_count = countValue - 8'h01;
      end else if (countDown && atBottom) begin
        next_countDown = 1'b0;
        next_count = countValue + 8'h01;
      end else if (countDown) begin
        next_count = countValue - 8'h01;
      end
    end else begin
      next_countDown = 1'b0;
      // non-pwm: normal mode wraps at max, mode two clears on compare a
      if (waveMode == 3'h2 && countValue == compareValueA) begin
        next_count = CNT_BOTTOM;
      end
    end
  end

  // a count write beats the tick so software can preload while running
  // direction is left alone by a count write; only reset or a tick changes it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      countValue <= RST_BYTE;
      countDown <= 1'b0;
    end else if (wrCount) begin
      countValue <= regWrData;
    end else if (tick) begin
      countValue <= next_count;
      countDown <= next_countDown;
    end
  end

  // compare values: buffered in pwm, loaded at top; immediate otherwise
  // without the buffer a write in mid-period could skip a match and
  // leave one period at full or zero duty
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bufCompareA <= RST_BYTE;
      bufCompareB <= RST_BYTE;
      compareValueA <= RST_BYTE;
      compareValueB <= RST_BYTE;
    end else begin
      if (wrCmpA) bufCompareA <= regWrData;
      if (wrCmpB) bufCompareB <= regWrData;
      if (!isPwm) begin
        if (wrCmpA) compareValueA <= regWrData;
        if (wrCmpB) compareValueB <= regWrData;
      end else if (tick && atTop) begin
        compareValueA <= bufCompareA;
        compareValueB <= bufCompareB;
      end
    end
  end

  // match and overflow events
  // flags are raised on the tick whose count shows the event
  assign matchA = countValue == compareValueA;
  assign matchB = countValue == compareValueB;
  assign ovfEvent = isFast ? atTop
                  : isPc ? (atBottom && countDown)
                  : (countValue == CNT_MAX);

  // waveform next-state for one channel
  // the level changes at the tick edge where the count shows the match,
  // so the pin lags the count by one timer clock
  // a match equal to top with the high mode bit set acts only at top
  // cur is returned unchanged when nothing applies
  function automatic logic waveNext(input logic cur, input logic [1:0] om,
                                    input logic match, input logic allowToggle,
                                    input logic cmpIsTop);
    logic res;
    res = cur;
    // fast pwm: top sets the starting level, the match flips it
    if (isFast) begin
      if (om[1]) begin
        if (atTop) begin
          res = (om == OM_CLEAR); // level at top
        end else if (match && !cmpIsTop) begin
          res = (om == OM_SET);
        end
      end else if (om == OM_TOGGLE && allowToggle && match) begin
        res = ~cur;
      end
    end else if (isPc) begin
      // phase-correct: the count direction picks set or clear
      if (om[1]) begin
        if (cmpIsTop) begin
          if (atTop) begin
            res = (om == OM_SET);
          end
        end else if (match) begin
          res = countDown ? (om == OM_CLEAR) : (om == OM_SET);
        end
      end else if (om == OM_TOGGLE && allowToggle && match) begin
        res = ~cur;
      end
    end else if (match) begin
      // non-pwm: the mode alone names the action
      unique case (om)
        OM_TOGGLE: res = ~cur;
        OM_CLEAR: res = 1'b0;
        OM_SET: res = 1'b1;
        default: res = cur;
      endcase
    end
    return res;
  endfunction : waveNext

  // channel b never toggles in pwm: that setting is reserved
  // a process, not an assign, so the mode and landmarks that the
  // function reads are part of what wakes it
  always_comb begin
    next_waveA = waveNext(waveOutA, outModeA, matchA,
                          timerControlBReg[CB_WAVE_HI_POS],
                          compareValueA == topValue);
    next_waveB = waveNext(waveOutB, outModeB, matchB,
                          1'b0, compareValueB == topValue);
  end

  // output compare registers; they hold between ticks
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      waveOutA <= 1'b0;
      waveOutB <= 1'b0;
    end else if (tick) begin
      waveOutA <= next_waveA;
      waveOutB <= next_waveB;
    end
  end

  // the pin copies the register as it will stand after this edge; off a
  // tick that is the held level, never a pending next value
  assign pinWaveA = tick ? next_waveA : waveOutA;
  assign pinWaveB = tick ? next_waveB : waveOutB;

  // pin override: nonzero mode selects the waveform, direction gates the driver
  // the override ignores the wave mode, so a stopped timer still owns the pin
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pinOut <= 2'h0;
    end else begin
      pinOut[0] <= (outModeA != OM_OFF) ? pinWaveA : portData[0];
      pinOut[1] <= (outModeB != OM_OFF) ? pinWaveB : portData[1];
    end
  end
  // the enable follows the direction bit only; the mode never turns it on
  assign pinOe = pinDir;

  // control registers; reserved bits forced to zero
  // control b bits 7:4 stay zero: the force strobes are not built
  // the interrupt mask keeps only the three event bits
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      timerWaveformControlA <= RST_BYTE;
      timerControlBReg <= RST_BYTE;
      irqMask <= RST_BYTE;
      pinDir <= 2'h0;
    end else begin
      if (wrCtrlA) timerWaveformControlA <= regWrData & CA_RW_MASK;
      if (wrCtrlB) timerControlBReg <= regWrData & CB_RW_MASK;
      if (regWrEn && regAddr == ADDR_IRQ_MASK) irqMask <= regWrData & IRQ_USED_MASK;
      if (regWrEn && regAddr == ADDR_PIN_DIR) pinDir <= regWrData[1:0];
    end
  end

  // sticky status; a new event wins over the read that clears it
  // match flags count in every mode; only overflow depends on the mode
  // reads of other addresses leave the flags alone
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqStatus <= RST_BYTE;
    end else begin
      if (rdStatus) irqStatus <= RST_BYTE;
      if (tick && ovfEvent) irqStatus[IRQ_OVF_POS] <= 1'b1;
      if (tick && matchA) irqStatus[IRQ_MATCH_A_POS] <= 1'b1;
      if (tick && matchB) irqStatus[IRQ_MATCH_B_POS] <= 1'b1;
    end
  end

  // level interrupt, high while any unmasked status bit stands
  // combinational from registers only, so it cannot glitch on a strobe
  assign irq = |(irqStatus & irqMask);

  // read data, one cycle after the read strobe
  // compare reads return the buffer, the value software last wrote
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      regRdData <= RST_BYTE;
    end else if (regRdEn) begin
      unique case (regAddr)
        ADDR_CTRL_A: regRdData <= timerWaveformControlA;
        ADDR_CTRL_B: regRdData <= timerControlBReg;
        ADDR_COUNT: regRdData <= countValue;
        ADDR_CMP_A: regRdData <= bufCompareA;
        ADDR_CMP_B: regRdData <= bufCompareB;
        ADDR_IRQ_STATUS: regRdData <= irqStatus;
        ADDR_IRQ_MASK: regRdData <= irqMask;
        ADDR_PIN_DIR: regRdData <= {6'h00, pinDir};
        default: regRdData <= RST_BYTE;
      endcase
    end
  end

endmodule : tpw_waveform_unit

// file: tpw_load.sv
`timescale 1ns/1ns
module tpw_load (
  // pin drive from the timer
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe,
  // level the external load sees
  output logic [1:0] pinLevel
);
  // a released pin falls to the pull-down, never keeps the last driven value
  assign pinLevel = pinOut & pinOe;
endmodule : tpw_load

// file: tpw_chk_sva.sv
`timescale 1ns/1ns
module tpw_chk
  import tpw_pkg::*;
(
  // clock, reset and register port
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  // interrupt and pins
  input wire logic irq,
  input wire logic [1:0] portData,
  input wire logic waveOutA,
  input wire logic waveOutB,
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe
);
  logic [7:0] ctrlA;
  logic [7:0] ctrlB;
  logic [7:0] mask;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // shadow of both control registers and the mask so mode-dependent checks know the mode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrlA <= RST_BYTE;
      ctrlB <= RST_BYTE;
      mask <= RST_BYTE;
    end else if (regWrEn) begin
      case (regAddr)
        ADDR_CTRL_A: ctrlA <= regWrData & CA_RW_MASK;
        ADDR_CTRL_B: ctrlB <= regWrData & CB_RW_MASK;
        ADDR_IRQ_MASK: mask <= regWrData;
        default: ;
      endcase
    end
  end
  chk_ctrl_read: assert property (
    regRdEn && regAddr == ADDR_CTRL_A |=> regRdData == $past(ctrlA))
    else $error("control a read back wrong");
  chk_dir_follow: assert property (
    regWrEn && regAddr == ADDR_PIN_DIR |=> pinOe == $past(regWrData[1:0]))
    else $error("pin enable not following direction");
  chk_pin_wave: assert property (
    !$past(srst) && $past(ctrlA[7:6]) != OM_OFF |-> pinOut[0] == waveOutA)
    else $error("pin a not overridden by waveform");
  chk_pin_port: assert property (
    !$past(srst) && $past(ctrlA[5:4]) == OM_OFF |-> pinOut[1] == $past(portData[1]))
    else $error("pin b lost its port data");
  chk_stop_hold: assert property (
    $past(ctrlB[2:0]) == 3'h0 && !$past(regWrEn) |-> $stable(waveOutA) && $stable(waveOutB))
    else $error("waveform moved while stopped");
  chk_irq_masked: assert property (mask[2:0] == 3'h0 |-> !irq)
    else $error("interrupt with everything masked");
  chk_b_reserved: assert property (
    $past(ctrlA[0]) && $past(ctrlA[5:4]) == OM_TOGGLE |-> $stable(waveOutB))
    else $error("channel b acted on reserved setting");
  chk_a_gate: assert property (
    $past(ctrlA[0]) && !$past(ctrlB[3]) && $past(ctrlA[7:6]) == OM_TOGGLE |-> $stable(waveOutA))
    else $error("channel a toggled without high mode bit");
endmodule : tpw_chk
bind tpw_waveform_unit tpw_chk tpw_chk_i (.*);

// file: tb.sv
`timescale 1ns/1ns
module tb
  import tpw_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [1:0] portData = 2'h0;
  logic [7:0] regRdData;
  logic irq;
  logic waveOutA;
  logic waveOutB;
  logic [1:0] pinOut;
  logic [1:0] pinOe;
  logic [1:0] pinLevel;
  logic rdPrev = 1'b0;
  logic peek = 1'b0;
  logic [15:0] expQ[$];
  logic [7:0] ca;
  logic [7:0] c;
  logic pc;
  logic wh;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  tpw_waveform_unit tpw_waveform_unit_i (.*);
  tpw_load tpw_load_i (.*);

  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    if (errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [7:0] seen, input logic [15:0] e);
    num_checks++;
    if ((seen & e[15:8]) !== e[7:0]) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, e[7:0], seen & e[15:8]);
    end
  endtask : check

  // watcher: oldest note against each read answer or pin look; also the hang limit
  always @(posedge ref_clk) begin
    rdPrev <= regRdEn;
    cycles <= cycles + 1;
    if (rdPrev) check("rdata", regRdData, expQ.pop_front());
    if (peek) check("pins", {3'h0, pinLevel, irq, waveOutB, waveOutA}, expQ.pop_front());
    if (cycles == 40000) begin
      errors++;
      conclude();
    end
  end

  task automatic rst();
    srst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
  endtask : rst

  // strobes drop for one edge between transfers so no signal is set twice at once
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge ref_clk);
    regWrEn <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  // a read (rdq high) or a look at the pins; the note goes in the queue first
  task automatic ask(input logic rdq, input logic [3:0] a, input logic [7:0] e,
                     input logic [7:0] m);
    expQ.push_back({m, e & m});
    regAddr <= a;
    regRdEn <= rdq;
    peek <= !rdq;
    @(posedge ref_clk);
    regRdEn <= 1'b0;
    peek <= 1'b0;
    @(posedge ref_clk);
  endtask : ask

  // reference counter and channel a output over n ticks: {count, out, overflow}
  function automatic logic [9:0] model(input logic [7:0] ca, input logic wh,
      input logic [7:0] s, input logic [7:0] c0, input logic [7:0] cb, input int n);
    logic [7:0] cnt;
    logic [7:0] cc;
    logic [7:0] top;
    logic up;
    logic o;
    logic ov;
    logic act;
    cnt = s;
    cc = c0;
    up = 1'b1;
    o = 1'b0;
    ov = 1'b0;
    for (int i = 0; i < n; i++) begin
      top = wh ? cc : CNT_MAX;
      act = (cnt == cc) && !(ca[7] && cc == top);
      if (act && ca[7:6] == OM_TOGGLE && wh) o = ~o;
      if (act && ca[7]) o = ca[1] ? ca[6] : (ca[6] ~^ up);
      if (cnt == top && ca[1]) begin
        if (ca[7]) o = ~ca[6];
        ov = 1'b1;
        cnt = CNT_BOTTOM;
        cc = cb;
      end else if (cnt == top && up) begin
        up = 1'b0;
        if (ca[7] && cc == top) o = ca[6];
        cnt = cnt - 8'h01;
        cc = cb;
      end else if (cnt == CNT_BOTTOM && !up) begin
        up = 1'b1;
        cnt = 8'h01;
        ov = 1'b1;
      end else begin
        cnt = up ? cnt + 8'h01 : cnt - 8'h01;
      end
    end
    return {cnt, o, ov};
  endfunction : model

  // preload while stopped, run exactly n full-rate ticks, stop, then inspect
  task automatic run(input logic [7:0] ca, input logic wh, input logic [7:0] s,
                     input logic [7:0] c0, input logic [7:0] cb, input int n);
    logic [9:0] m;
    m = model(ca, wh, s, c0, cb, n);
    rst();
    portData <= 2'($urandom);
    wr(ADDR_CMP_A, c0);
    wr(ADDR_COUNT, s);
    wr(ADDR_PIN_DIR, 8'h03);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_CTRL_A, ca);
    wr(ADDR_CMP_A, cb);
    wr(ADDR_CTRL_B, {4'h0, wh, 3'h1});
    repeat (n - 2) @(posedge ref_clk);
    wr(ADDR_CTRL_B, {4'h0, wh, 3'h0});
    ask(1'b0, 4'h0, {3'h0, (ca[5:4] == OM_OFF) ? portData[1] : 1'b0, m[1], m[0], 1'b0, m[1]},
        8'h1f);
    ask(1'b1, ADDR_COUNT, m[9:2], 8'hff);
    ask(1'b1, ADDR_IRQ_STATUS, {7'h0, m[0]}, 8'h01);
    ask(1'b1, ADDR_IRQ_STATUS, 8'h00, 8'h01);
    ask(1'b1, ADDR_CMP_A, cb, 8'hff);
  endtask : run

  // main sequence
  initial begin
    void'($urandom(22205));
    rst();
    ask(1'b1, ADDR_CTRL_A, RST_BYTE, 8'hff);
    wr(ADDR_CTRL_A, 8'hff);
    ask(1'b1, ADDR_CTRL_A, CA_RW_MASK, 8'hff);
    ask(1'b1, 4'h8, 8'h00, 8'hff);
    run(8'h83, 1'b0, 8'hfe, 8'h00, 8'h00, 2);
    run(8'h83, 1'b0, 8'hfe, 8'h00, 8'h00, 3);
    run(8'hc3, 1'b0, 8'h00, 8'hff, 8'hff, 600);
    run(8'h43, 1'b1, 8'h00, 8'h00, 8'h00, 5);
    // non-pwm: two ticks from count 4 reach the match at 5 once
    rst();
    wr(ADDR_CMP_A, 8'h05);
    wr(ADDR_PIN_DIR, 8'h03);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_COUNT, 8'h04);
      wr(ADDR_CTRL_A, {2'(k % 3 + 1), 6'h00});
      wr(ADDR_CTRL_B, 8'h01);
      wr(ADDR_CTRL_B, 8'h00);
      ask(1'b0, 4'h0, {4'h0, ~k[0], 2'h0, ~k[0]}, 8'h09);
    end
    for (int i = 0; i < 24; i++) begin
      pc = 1'($urandom);
      wh = 1'($urandom);
      ca = {2'h1 + 2'($urandom % 3), 1'b0, 1'($urandom), 2'h0, ~pc, 1'b1};
      c = pc ? 8'h02 + 8'($urandom % 252) : 8'($urandom);
      run(ca, wh, wh ? 8'($urandom % (c + 1)) : 8'($urandom), c,
          pc ? 8'h02 + 8'($urandom % 252) : 8'($urandom), int'(2 + $urandom % 600));
    end
    repeat (3) @(posedge ref_clk);
    conclude();
  end
endmodule : tb
